// >>> src/ebc_buffer_control.v
// Purpose: control registers and packet buffer management of an Ethernet controller
// Assumes: host register port already decoded from the serial command layer
// Notes:   DMA, MAC and PHY engines are outside; their status arrives on ports
//
// How it works
// - Transmit reset bit holds transmit logic in reset while set.
// - Receive reset bit holds receive logic in reset while set.
// - DMA bit starts the engine and reads one while it is busy.
// - Checksum select chooses checksum over copy for the DMA engine.
// - Transmit request reads one until the transmit logic goes idle.
// - Receive enable lets filtered packets into the ring; when clear, new packets are ignored.
// - Two bank bits choose which register bank host accesses reach.
// - Auto step advances the data port pointer on each access.
// - Writing one to packet decrement lowers the packet count, self-clears.
// - Sleep bit puts MAC, PHY and control logic into low power.
// - Low-current regulator bit counts only while sleeping.
// - Eight kilobyte buffer split into programmable receive and transmit regions.
// - Ring start and end bytes both belong to the ring.
// - Bytes written in order; after ring end comes ring start.
// - Ring works even when it wraps past the top address.
// - Hardware write pointer is read-only, updated per good packet.
// - Writes stop before the guard pointer; overflow data is dropped.
// - Everything outside the ring is transmit space, host managed.
`include "ebc_defines.vh"
`default_nettype none
module ebc_buffer_control #(
	parameter AW = 13,
	parameter DW = 8
) (
	input  wire          i_clk_sys,
	input  wire          i_reset_n,
	input  wire          i_reg_wr,
	input  wire          i_reg_rd_unused,
	input  wire [2:0]    i_reg_sel,
	input  wire [15:0]   i_reg_wdata,
	output reg  [15:0]   o_reg_rdata,
	input  wire          i_data_wr,
	input  wire          i_data_rd,
	input  wire [DW-1:0] i_data_wdata,
	output reg  [DW-1:0] o_data_rdata,
	input  wire          i_rx_valid,
	input  wire [DW-1:0] i_rx_byte,
	input  wire          i_rx_last,
	input  wire          i_rx_good,
	input  wire          i_rx_filter_pass,
	input  wire          i_tx_done,
	input  wire          i_dma_done,
	input  wire          i_pkt_inc,
	output wire          o_tx_reset,
	output wire          o_rx_reset,
	output wire          o_dma_start,
	output wire          o_dma_checksum,
	output wire          o_tx_start,
	output wire [1:0]    o_bank_select,
	output wire          o_sleep,
	output wire          o_reg_low_current,
	output reg  [7:0]    o_pending_packet_count,
	output reg           o_rx_dropped
);
	localparam DEPTH = 1 << AW;

	reg  [DW-1:0] mem [0:DEPTH-1];
	reg  [7:0]    ctrl1;
	reg  [7:0]    ctrl2;
	reg           dma_busy;
	reg           tx_busy;
	reg  [AW-1:0] rx_ring_start;
	reg  [AW-1:0] rx_ring_end;
	reg  [AW-1:0] rx_guard_pointer;
	reg  [AW-1:0] rx_hw_write_pointer;
	reg  [AW-1:0] rx_cur;
	reg           rx_active;
	reg           rx_overflow;
	reg  [AW-1:0] buffer_read_pointer;
	reg  [AW-1:0] buffer_write_pointer;
	wire [AW-1:0] rx_next;
	wire [AW-1:0] rd_next;
	wire          c1_wr;
	wire          c2_wr;
	wire          rx_on;
	wire          rx_store;
	wire          dec_req;
	reg  [DW+3:0] rx_meta;
	reg  [DW+3:0] rx_sync;
	wire          rx_valid_q;
	wire          rx_last_q;
	wire          rx_good_q;
	wire          rx_pass_q;
	wire [DW-1:0] rx_byte_q;

	// Receive side comes from the link domain: two flops before use
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_meta <= {(DW+4){1'b0}};
			rx_sync <= {(DW+4){1'b0}};
		end else begin
			rx_meta <= {i_rx_valid, i_rx_last, i_rx_good, i_rx_filter_pass, i_rx_byte};
			rx_sync <= rx_meta;
		end
	end
	assign {rx_valid_q, rx_last_q, rx_good_q, rx_pass_q, rx_byte_q} = rx_sync;

	// Ring step wraps end to start, valid across the top address
	assign rx_next = (rx_cur == rx_ring_end) ? rx_ring_start : rx_cur + 1'b1;
	assign rd_next = (buffer_read_pointer == rx_ring_end) ? rx_ring_start
		: buffer_read_pointer + 1'b1;
	assign c1_wr = i_reg_wr && (i_reg_sel == `EBC_SEL_C1);
	assign c2_wr = i_reg_wr && (i_reg_sel == `EBC_SEL_C2);
	assign rx_on = ctrl1[`EBC_C1_RX_ACCEPT_ENABLE] && !ctrl1[`EBC_C1_RX_LOGIC_RESET];
	assign rx_store = rx_valid_q && rx_active && !rx_overflow;
	assign dec_req = c2_wr && i_reg_wdata[`EBC_C2_PACKET_COUNT_DECREMENT];

	assign o_tx_reset = ctrl1[`EBC_C1_TX_LOGIC_RESET];
	assign o_rx_reset = ctrl1[`EBC_C1_RX_LOGIC_RESET];
	assign o_dma_start = dma_busy;
	assign o_dma_checksum = ctrl1[`EBC_C1_CSUM];
	assign o_tx_start = tx_busy;
	assign o_bank_select = ctrl1[1:0];
	assign o_sleep = ctrl2[`EBC_C2_SLEEP];
	assign o_reg_low_current = ctrl2[`EBC_C2_SLEEP] & ctrl2[`EBC_C2_VREG];

	// Control registers and status bits
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl1 <= `EBC_C1_RESET;
			ctrl2 <= `EBC_C2_RESET;
			dma_busy <= 1'b0;
			tx_busy <= 1'b0;
			o_pending_packet_count <= 8'h00;
		end else begin
			if (c1_wr) begin
				ctrl1 <= i_reg_wdata[7:0];
			end
			if (c2_wr) begin
				ctrl2 <= i_reg_wdata[7:0] & `EBC_C2_WMASK & 8'hBF;
			end
			// Start wins over completion in the same cycle
			if (c1_wr && i_reg_wdata[`EBC_C1_DMA]) begin
				dma_busy <= 1'b1;
			end else if (i_dma_done) begin
				dma_busy <= 1'b0;
			end
			if (c1_wr && i_reg_wdata[`EBC_C1_TXREQ] && !i_reg_wdata[`EBC_C1_TX_LOGIC_RESET]) begin
				tx_busy <= 1'b1;
			end else if (i_tx_done || ctrl1[`EBC_C1_TX_LOGIC_RESET]) begin
				tx_busy <= 1'b0;
			end
			if (dec_req && !i_pkt_inc) begin
				if (o_pending_packet_count != 8'h00) begin
					o_pending_packet_count <= o_pending_packet_count - 8'h01;
				end
			end else if (i_pkt_inc && !dec_req) begin
				if (o_pending_packet_count != 8'hFF) begin
					o_pending_packet_count <= o_pending_packet_count + 8'h01;
				end
			end
		end
	end

	// Pointer registers and receive ring engine
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_ring_start <= `EBC_RXST_RESET;
			rx_ring_end <= `EBC_RXND_RESET;
			rx_guard_pointer <= `EBC_RXST_RESET;
			rx_hw_write_pointer <= `EBC_RXST_RESET;
			rx_cur <= `EBC_RXST_RESET;
			rx_active <= 1'b0;
			rx_overflow <= 1'b0;
			o_rx_dropped <= 1'b0;
			buffer_read_pointer <= {AW{1'b0}};
			buffer_write_pointer <= {AW{1'b0}};
		end else begin
			o_rx_dropped <= 1'b0;
			// Bounds only change while reception is off
			if (i_reg_wr && !ctrl1[`EBC_C1_RX_ACCEPT_ENABLE]) begin
				if (i_reg_sel == `EBC_SEL_RXST) begin
					rx_ring_start <= i_reg_wdata[AW-1:0];
					rx_hw_write_pointer <= i_reg_wdata[AW-1:0];
					rx_cur <= i_reg_wdata[AW-1:0];
				end
				if (i_reg_sel == `EBC_SEL_RXND) begin
					rx_ring_end <= i_reg_wdata[AW-1:0];
				end
			end
			if (i_reg_wr && i_reg_sel == `EBC_SEL_GUARD) begin
				rx_guard_pointer <= i_reg_wdata[AW-1:0];
			end
			if (i_reg_wr && i_reg_sel == `EBC_SEL_RDPT) begin
				buffer_read_pointer <= i_reg_wdata[AW-1:0];
			end else if (i_data_rd && ctrl2[`EBC_C2_AUTO]) begin
				buffer_read_pointer <= rd_next;
			end
			if (i_reg_wr && i_reg_sel == `EBC_SEL_WRPT) begin
				buffer_write_pointer <= i_reg_wdata[AW-1:0];
			end else if (i_data_wr && ctrl2[`EBC_C2_AUTO]) begin
				buffer_write_pointer <= buffer_write_pointer + 1'b1;
			end
			if (ctrl1[`EBC_C1_RX_LOGIC_RESET]) begin
				rx_active <= 1'b0;
				rx_overflow <= 1'b0;
				rx_cur <= rx_hw_write_pointer;
			end else if (rx_valid_q) begin
				if (!rx_active && !rx_on) begin
					o_rx_dropped <= rx_last_q;
				end else begin
					if (!rx_active) begin
						rx_active <= rx_pass_q && rx_on;
					end
					if (rx_store || (!rx_active && rx_pass_q && rx_on)) begin
						if (rx_cur == rx_guard_pointer) begin
							rx_overflow <= 1'b1;
						end else begin
							rx_cur <= rx_next;
						end
					end
					if (rx_last_q) begin
						rx_active <= 1'b0;
						rx_overflow <= 1'b0;
						// Commit only good, complete packets
						if (rx_good_q && !rx_overflow && rx_cur != rx_guard_pointer
							&& (rx_active || (rx_pass_q && rx_on))) begin
							rx_hw_write_pointer <= rx_next;
							rx_cur <= rx_next;
						end else begin
							rx_cur <= rx_hw_write_pointer;
							o_rx_dropped <= 1'b1;
						end
					end
				end
			end
		end
	end

	// Buffer memory: receive writes win over host data-port writes
	always @(posedge i_clk_sys) begin
		if (rx_valid_q && !ctrl1[`EBC_C1_RX_LOGIC_RESET] && (rx_active || (rx_pass_q && rx_on))
			&& !rx_overflow && rx_cur != rx_guard_pointer) begin
			mem[rx_cur] <= rx_byte_q;
		end else if (i_data_wr) begin
			mem[buffer_write_pointer] <= i_data_wdata;
		end
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_data_rdata <= {DW{1'b0}};
		end else if (i_data_rd) begin
			o_data_rdata <= mem[buffer_read_pointer];
		end
	end

	// Register readback
	always @* begin
		case (i_reg_sel)
			`EBC_SEL_C1: o_reg_rdata = {8'h00, ctrl1[7:6], dma_busy, ctrl1[4], tx_busy, ctrl1[2:0]};
			`EBC_SEL_C2: o_reg_rdata = {8'h00, ctrl2};
			`EBC_SEL_RXST: o_reg_rdata = {{(16-AW){1'b0}}, rx_ring_start};
			`EBC_SEL_RXND: o_reg_rdata = {{(16-AW){1'b0}}, rx_ring_end};
			`EBC_SEL_GUARD: o_reg_rdata = {{(16-AW){1'b0}}, rx_guard_pointer};
			`EBC_SEL_RDPT: o_reg_rdata = {{(16-AW){1'b0}}, buffer_read_pointer};
			`EBC_SEL_WRPT: o_reg_rdata = {{(16-AW){1'b0}}, buffer_write_pointer};
			default: o_reg_rdata = {{(16-AW){1'b0}}, rx_hw_write_pointer};
		endcase
	end
endmodule // ebc_buffer_control
`default_nettype wire

// >>> src/ebc_defines.vh
// Purpose: constants for the Ethernet buffer control block
// Assumes: 8-bit control registers, 13-bit buffer addresses
// Notes:   bit positions and reset values as macros
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH
`define EBC_C1_TX_LOGIC_RESET      7
`define EBC_C1_RX_LOGIC_RESET      6
`define EBC_C1_DMA        5
`define EBC_C1_CSUM       4
`define EBC_C1_TXREQ      3
`define EBC_C1_RX_ACCEPT_ENABLE       2
`define EBC_C2_AUTO       7
`define EBC_C2_PACKET_COUNT_DECREMENT     6
`define EBC_C2_SLEEP      5
`define EBC_C2_VREG       3
`define EBC_C1_RESET      8'h00
`define EBC_C2_RESET      8'h80
`define EBC_C2_WMASK      8'hA8
`define EBC_SEL_C1        3'h0
`define EBC_SEL_C2        3'h1
`define EBC_SEL_RXST      3'h2
`define EBC_SEL_RXND      3'h3
`define EBC_SEL_GUARD     3'h4
`define EBC_SEL_RDPT      3'h5
`define EBC_SEL_WRPT      3'h6
`define EBC_RXST_RESET    13'h0000
`define EBC_RXND_RESET    13'h1FFF
`define EBC_DMA_CYCLES    16'h0010
`endif

// >>> tb/ebc_buffer_control_checker.sv
// Purpose: port assertions for the buffer control block
// Assumes: one clock, async active-low reset
// Notes:   bound to the design at the foot
`include "ebc_defines.vh"
`default_nettype none
module ebc_buffer_control_checker (
	input wire logic        i_clk_sys, i_reset_n, i_reg_wr, i_tx_done, i_dma_done, i_pkt_inc,
	input wire logic [2:0]  i_reg_sel,
	input wire logic [15:0] i_reg_wdata, o_reg_rdata,
	input wire logic        o_tx_reset, o_rx_reset, o_dma_start, o_dma_checksum, o_tx_start,
	input wire logic [1:0]  o_bank_select,
	input wire logic        o_sleep, o_reg_low_current,
	input wire logic [7:0]  o_pending_packet_count
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	logic c1w, c2w;
	assign c1w = i_reg_wr && i_reg_sel == `EBC_SEL_C1;
	assign c2w = i_reg_wr && i_reg_sel == `EBC_SEL_C2;
	tx_reset_a: assert property (c1w |=> o_tx_reset == $past(i_reg_wdata[7]))
		else $error("tx reset bit not followed");
	rx_reset_a: assert property (c1w |=> o_rx_reset == $past(i_reg_wdata[6]))
		else $error("rx reset bit not followed");
	dma_start_a: assert property (c1w && i_reg_wdata[5] |=> o_dma_start)
		else $error("dma not started");
	dma_idle_a: assert property (i_dma_done && !(c1w && i_reg_wdata[5]) |=> !o_dma_start)
		else $error("dma busy after done");
	csum_sel_a: assert property (c1w |=> o_dma_checksum == $past(i_reg_wdata[4]))
		else $error("checksum select wrong");
	tx_idle_a: assert property (i_tx_done && !(c1w && i_reg_wdata[3]) |=> !o_tx_start)
		else $error("tx busy after done");
	bank_sel_a: assert property (c1w |=> o_bank_select == $past(i_reg_wdata[1:0]))
		else $error("bank select wrong");
	pkt_dec_a: assert property (c2w && i_reg_wdata[6] && !i_pkt_inc
		&& o_pending_packet_count != 8'h00 |=>
		o_pending_packet_count == $past(o_pending_packet_count) - 8'h01)
		else $error("packet count not lowered");
	dec_clear_a: assert property (i_reg_sel == `EBC_SEL_C2 |-> !o_reg_rdata[6])
		else $error("decrement bit reads one");
	sleep_set_a: assert property (c2w |=> o_sleep == $past(i_reg_wdata[5]))
		else $error("sleep bit not followed");
	low_cur_a: assert property (c2w ##1 !c2w |->
		o_reg_low_current == $past(i_reg_wdata[5] & i_reg_wdata[3]))
		else $error("low current wrong");
endmodule // ebc_buffer_control_checker
bind ebc_buffer_control ebc_buffer_control_checker u_chk (.i_clk_sys(i_clk_sys),
	.i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_tx_done(i_tx_done),
	.i_dma_done(i_dma_done), .i_pkt_inc(i_pkt_inc), .i_reg_sel(i_reg_sel),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_tx_reset(o_tx_reset),
	.o_rx_reset(o_rx_reset), .o_dma_start(o_dma_start), .o_dma_checksum(o_dma_checksum),
	.o_tx_start(o_tx_start), .o_bank_select(o_bank_select), .o_sleep(o_sleep),
	.o_reg_low_current(o_reg_low_current), .o_pending_packet_count(o_pending_packet_count));
`default_nettype wire

// >>> tb/ebc_buffer_control_tb.sv
// Purpose: self-checking bench for the buffer control block
// Assumes: 100 MHz clock, inputs driven at the falling edge
// Notes:   reads are checked against an expectation queue
`include "ebc_defines.vh"
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module ebc_buffer_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, wr = 0, drd = 0, dwr = 0, txd = 0, dmad = 0, inc = 0;
	logic go = 0, rd_pend = 0, drq = 0, seen_drop = 0, clr_drop = 0, rxv, rxl, busy, drop;
	logic [2:0] sel = 0;
	logic [15:0] wdata = 0, rdata, e16, exp_v, q[$];
	logic [7:0] dwd = 0, drdata, cnt, b0 = 0, rxb;
	int err_count = 0, compares = 0, seed = 32'h35022869;
	always #5 clk = ~clk;
	ebc_buffer_control dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_wr(wr),
		.i_reg_rd_unused(1'b0), .i_reg_sel(sel), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_data_wr(dwr), .i_data_rd(drd), .i_data_wdata(dwd), .o_data_rdata(drdata),
		.i_rx_valid(rxv), .i_rx_byte(rxb), .i_rx_last(rxl), .i_rx_good(1'b1),
		.i_rx_filter_pass(1'b1), .i_tx_done(txd), .i_dma_done(dmad), .i_pkt_inc(inc),
		.o_tx_reset(), .o_rx_reset(), .o_dma_start(), .o_dma_checksum(), .o_tx_start(),
		.o_bank_select(), .o_sleep(), .o_reg_low_current(),
		.o_pending_packet_count(cnt), .o_rx_dropped(drop));
	ebc_rx_source src (.i_clk_sys(clk), .i_go(go), .i_first(b0), .o_rx_valid(rxv),
		.o_rx_last(rxl), .o_busy(busy), .o_rx_byte(rxb));
	task automatic wreg(input logic [2:0] s, input logic [15:0] d);
		@(negedge clk) {wr, sel, wdata} = {1'b1, s, d};
		@(negedge clk) wr = 0;
	endtask
	task automatic rreg(input logic [2:0] s, input logic [15:0] e);
		@(negedge clk) {rd_pend, sel} = {1'b1, s};
		q.push_back(e);
		@(negedge clk) rd_pend = 0;
	endtask
	task automatic dat(input logic w, input logic [7:0] d);
		@(negedge clk) {dwr, drd, dwd} = {w, !w, d};
		if (!w) q.push_back({8'h00, d});
		@(negedge clk) {dwr, drd} = 2'b00;
	endtask
	task automatic pkt;
		@(negedge clk) go = 1;
		repeat (2) @(negedge clk);
		go = 0;
		for (int k = 0; k < 300 && busy; k++) @(negedge clk);
		repeat (3) @(negedge clk);
	endtask
	task automatic end_sim;
		if (err_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		drq <= drd;
		if (clr_drop)
			seen_drop <= 0;
		else if (drop)
			seen_drop <= 1;
		if (rd_pend || drq) begin
			exp_v = q.pop_front();
			`CHK("read", exp_v, rd_pend ? rdata : {8'h00, drdata})
		end
	end
	initial begin
		#200000 err_count++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n = 1;
		rreg(`EBC_SEL_C1, {8'h00, `EBC_C1_RESET});
		rreg(`EBC_SEL_C2, {8'h00, `EBC_C2_RESET});
		rreg(`EBC_SEL_RXND, {3'h0, `EBC_RXND_RESET});
		for (int b = 0; b < 4; b++) begin
			e16 = $random(seed);
			e16 = {8'h00, e16[7:6], 1'b0, e16[4], 2'b00, 2'(b)};
			wreg(`EBC_SEL_C1, e16);
			rreg(`EBC_SEL_C1, e16);
		end
		wreg(`EBC_SEL_C1, 16'h0028);
		rreg(`EBC_SEL_C1, 16'h0028);
		@(negedge clk) {dmad, txd} = 2'b11;
		@(negedge clk) {dmad, txd} = 2'b00;
		rreg(`EBC_SEL_C1, 16'h0000);
		wreg(`EBC_SEL_C2, 16'h00FF);
		rreg(`EBC_SEL_C2, {8'h00, `EBC_C2_WMASK});
		@(negedge clk) inc = 1;
		repeat (2) @(negedge clk);
		inc = 0;
		wreg(`EBC_SEL_C2, 16'h00C0);
		`CHK("count", 8'h01, cnt)
		wreg(`EBC_SEL_RXST, 16'h1FFE);
		wreg(`EBC_SEL_RXND, 16'h0003);
		wreg(`EBC_SEL_GUARD, 16'h0003);
		b0 = $random(seed);
		pkt;
		rreg(3'h7, 16'h1FFE);
		wreg(`EBC_SEL_C1, 16'h0004);
		@(negedge clk) clr_drop = 1;
		@(negedge clk) clr_drop = 0;
		pkt;
		rreg(3'h7, 16'h0001);
		`CHK("kept", 1'b0, seen_drop)
		@(negedge clk) clr_drop = 1;
		@(negedge clk) clr_drop = 0;
		wreg(3'h7, 16'h0AAA);
		wreg(`EBC_SEL_RXST, 16'h0100);
		rreg(3'h7, 16'h0001);
		rreg(`EBC_SEL_RXST, 16'h1FFE);
		pkt;
		rreg(3'h7, 16'h0001);
		`CHK("dropped", 1'b1, seen_drop)
		wreg(`EBC_SEL_RDPT, 16'h1FFF);
		dat(0, b0 + 8'h01);
		dat(0, b0 + 8'h02);
		wreg(`EBC_SEL_C2, 16'h0000);
		wreg(`EBC_SEL_RDPT, 16'h1FFE);
		dat(0, b0);
		dat(0, b0);
		wreg(`EBC_SEL_C2, 16'h0080);
		wreg(`EBC_SEL_WRPT, 16'h0100);
		dat(1, 8'hA5);
		dat(1, 8'h5A);
		wreg(`EBC_SEL_RDPT, 16'h0100);
		dat(0, 8'hA5);
		dat(0, 8'h5A);
		repeat (4) @(negedge clk);
		end_sim;
	end
endmodule // ebc_buffer_control_tb
`default_nettype wire

// >>> tb/ebc_rx_source.sv
// Purpose: receive byte source on the far side
// Assumes: one byte per rising edge of a 160 ns link clock
// Notes:   link clock stands still between frames
`default_nettype none
module ebc_rx_source #(parameter int LEN = 3) (
	input  wire logic       i_clk_sys, i_go,
	input  wire logic [7:0] i_first,
	output var logic        o_rx_valid, o_rx_last, o_busy,
	output var logic [7:0]  o_rx_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic link = 0, link_q = 0;
	int   n = 0;
	initial {o_rx_valid, o_rx_last, o_busy, o_rx_byte} = 11'h000;
	always #80 if (o_busy) link = ~link;
	always @(negedge i_clk_sys) begin
		link_q <= link;
		o_rx_valid <= 1'b0;
		o_rx_last <= 1'b0;
		if (i_go && !o_busy) begin
			o_busy <= 1'b1;
			n <= 0;
		end else if (o_busy && link && !link_q) begin
			o_rx_valid <= 1'b1;
			o_rx_byte <= i_first + 8'(n);
			o_rx_last <= (n == LEN - 1);
			o_busy <= (n != LEN - 1);
			n <= n + 1;
		end else if (!o_busy) o_rx_byte <= ~o_rx_byte; // Idle line keeps moving
	end
endmodule // ebc_rx_source
`default_nettype wire
